// ===== core/tap_device.sv
// device end: tap controller, instruction, bypass, id and boundary registers
// Functional notes
// - id instruction shifts 32-bit identification code
// - instruction resets to id at reset
// - sample-z selects boundary register in shift
// - sample-z floats read bus while it is the current instruction
// - sample/preload captures pin levels in capture-dr
// - controller keeps test clock at most 20 MHz
// - keep sampled pins stable, else sampled value unreliable
// - captured sample shifts out through boundary register
// - preload leaves pattern on latched cell outputs
// - preload shifts in while sample shifts out
// - bypass selects single-bit bypass register
// - extest drives latched values onto output pins
// - extest selects boundary register in shift
// - cell 47 latch governs bus under extest
// - latched one drives bus, zero floats it
// - update-dr moves shifted cell into latch
// - tristate latch presets high on reset
// - reserved instruction codes still load and act as bypass
// - transitions follow tms on rising test clock
// - codes 000 001 010 100 111, rest reserved
// - capture-ir loads 01 into low bits
// - sample on rising edge, tdo on falling
// - five tms-high edges reset the controller
`timescale 1ns/1ns
module tap_device
    import tap_pkg::*;
#(
    parameter logic [31:0] ID_CODE = 32'h0abc_d001  // arbitrary value, bit 0 marks presence
) (
    tap_if.dev                    link,
    input  wire logic             sys_rst,
    input  wire logic [BSR_LEN-1:0] ring_in,
    input  wire logic             func_q_oe,
    output logic      [BSR_LEN-1:0] ring_drive,
    output logic                  extest_active,
    output logic                  q_bus_oe
);

    // -------------------------------------------------------------
    // decoding helpers
    // -------------------------------------------------------------
    // sixteen-state sequence
    function automatic tap_state_t tap_next(input tap_state_t s, input logic tms);
        tap_state_t n;
        n = s;
        unique case (s)
            TEST_LOGIC_RESET: n = tms ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
            RUN_TEST_IDLE:    n = tms ? SELECT_DR : RUN_TEST_IDLE;
            SELECT_DR:        n = tms ? SELECT_IR : CAPTURE_DR;
            CAPTURE_DR:       n = tms ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR:         n = tms ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR:         n = tms ? UPDATE_DR : PAUSE_DR;
            PAUSE_DR:         n = tms ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR:         n = tms ? UPDATE_DR : SHIFT_DR;
            UPDATE_DR:        n = tms ? SELECT_DR : RUN_TEST_IDLE;
            SELECT_IR:        n = tms ? TEST_LOGIC_RESET : CAPTURE_IR;
            CAPTURE_IR:       n = tms ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR:         n = tms ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR:         n = tms ? UPDATE_IR : PAUSE_IR;
            PAUSE_IR:         n = tms ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR:         n = tms ? UPDATE_IR : SHIFT_IR;
            UPDATE_IR:        n = tms ? SELECT_DR : RUN_TEST_IDLE;
        endcase
        return n;
    endfunction

    // reserved codes fall back to bypass so a stray load stays harmless
    function automatic dr_sel_t dr_select(input logic [IR_LEN-1:0] ir);
        dr_sel_t sel;
        sel = DR_BYPASS;
        case (ir)
            IR_IDCODE:     sel = DR_ID;
            IR_SAMPLE_Z:   sel = DR_BOUNDARY;
            IR_SAMPLE_PRE: sel = DR_BOUNDARY;
            IR_EXTEST:     sel = DR_BOUNDARY;
            default:       sel = DR_BYPASS;
        endcase
        return sel;
    endfunction

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    tap_state_t              st_q,        st_d;
    logic [IR_LEN-1:0]       ir_sh_q,     ir_sh_d;
    logic [IR_LEN-1:0]       ir_q,        ir_d;
    logic                    byp_q,       byp_d;
    logic [ID_LEN-1:0]       id_q,        id_d;
    logic [BSR_LEN-1:0]      bsr_q,       bsr_d;
    logic [BSR_LEN-1:0]      upd_q,       upd_d;
    logic [BSR_LEN-1:0]      ring_meta_q;
    logic [BSR_LEN-1:0]      ring_sync_q;
    logic                    tdo_q,       tdo_d;
    logic                    tdo_oe_q,    tdo_oe_d;
    dr_sel_t                 sel;
    logic [BSR_LEN-1:0]      snap;

    assign sel = dr_select(ir_q);

    // cell 47 has no pin; it captures its own latch so a sample reads it back
    always_comb begin
        snap               = ring_sync_q;
        snap[TRISTATE_BIT] = upd_q[TRISTATE_BIT];
    end

    // -------------------------------------------------------------
    // next-state logic, rising test clock
    // -------------------------------------------------------------
    always_comb begin
        // all test inputs taken on rising edge
        st_d    = tap_next(st_q, link.tms);
        ir_sh_d = ir_sh_q;
        ir_d    = ir_q;
        byp_d   = byp_q;
        id_d    = id_q;
        bsr_d   = bsr_q;
        upd_d   = upd_q;
        case (st_q)
            TEST_LOGIC_RESET: begin
                ir_d               = IR_IDCODE;
                upd_d[TRISTATE_BIT] = TRISTATE_RESET;
            end
            CAPTURE_IR: ir_sh_d = IR_CAPTURE;
            SHIFT_IR:   ir_sh_d = {link.tdi, ir_sh_q[IR_LEN-1:1]};
            UPDATE_IR:  ir_d = ir_sh_q;
            CAPTURE_DR: begin
                unique case (sel)
                    DR_ID:       id_d = ID_CODE;
                    DR_BOUNDARY: bsr_d = snap;
                    DR_BYPASS:   byp_d = BYPASS_CAPTURE;
                endcase
            end
            SHIFT_DR: begin
                unique case (sel)
                    DR_ID:       id_d = {link.tdi, id_q[ID_LEN-1:1]};
                    DR_BOUNDARY: bsr_d = {link.tdi, bsr_q[BSR_LEN-1:1]};
                    DR_BYPASS:   byp_d = link.tdi;
                endcase
            end
            UPDATE_DR: begin
                if (ir_q == IR_SAMPLE_PRE || ir_q == IR_EXTEST) begin
                    upd_d = bsr_q;
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge link.tck) begin
        if (sys_rst) begin
            st_q    <= TEST_LOGIC_RESET;
            ir_sh_q <= IR_CAPTURE;
            ir_q    <= IR_IDCODE;
            byp_q   <= BYPASS_CAPTURE;
            id_q    <= '0;
            bsr_q   <= '0;
            upd_q   <= BSR_LEN'(1) << TRISTATE_BIT;
        end else begin
            st_q    <= st_d;
            ir_sh_q <= ir_sh_d;
            ir_q    <= ir_d;
            byp_q   <= byp_d;
            id_q    <= id_d;
            bsr_q   <= bsr_d;
            upd_q   <= upd_d;
        end
    end

    // -------------------------------------------------------------
    // pin ring synchroniser into the test clock domain
    // -------------------------------------------------------------
    // unstable pins still sample, value unreliable
    always_ff @(posedge link.tck) begin
        if (sys_rst) begin
            ring_meta_q <= '0;
            ring_sync_q <= '0;
        end else begin
            ring_meta_q <= ring_in;
            ring_sync_q <= ring_meta_q;
        end
    end

    // -------------------------------------------------------------
    // serial output, falling test clock
    // -------------------------------------------------------------
    always_comb begin
        tdo_d    = 1'b0;
        tdo_oe_d = 1'b0;
        if (st_q == SHIFT_IR) begin
            tdo_d    = ir_sh_q[0];
            tdo_oe_d = 1'b1;
        end else if (st_q == SHIFT_DR) begin
            tdo_oe_d = 1'b1;
            unique case (sel)
                DR_ID:       tdo_d = id_q[0];
                DR_BOUNDARY: tdo_d = bsr_q[0];
                DR_BYPASS:   tdo_d = byp_q;
            endcase
        end
    end

    always_ff @(negedge link.tck) begin
        if (sys_rst) begin
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else begin
            tdo_q    <= tdo_d;
            tdo_oe_q <= tdo_oe_d;
        end
    end

    assign link.tdo    = tdo_q;
    assign link.tdo_oe = tdo_oe_q;

    // -------------------------------------------------------------
    // system pin control
    // -------------------------------------------------------------
    // latched values drive the pins
    assign ring_drive    = upd_q;
    assign extest_active = (ir_q == IR_EXTEST);

    always_comb begin
        q_bus_oe = func_q_oe;
        if (ir_q == IR_SAMPLE_Z) begin
            q_bus_oe = 1'b0;
        end else if (ir_q == IR_EXTEST) begin
            q_bus_oe = upd_q[TRISTATE_BIT];
        end
    end

endmodule

// ===== core/tap_host.sv
// controller end: divides the link clock and runs reset, ir and dr scans
`timescale 1ns/1ns
module tap_host
    import tap_pkg::*;
#(
    parameter int MAX_LEN = 128
) (
    input  wire logic               sys_clk,
    input  wire logic               sys_rst,
    tap_if.ctl                      link,
    input  wire logic               cmd_valid,
    output logic                    cmd_ready,
    input  wire logic [1:0]         cmd_op,
    input  wire logic [7:0]         cmd_len,
    input  wire logic [MAX_LEN-1:0] cmd_data,
    output logic                    rsp_valid,
    output logic      [MAX_LEN-1:0] rsp_data
);

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    host_state_t          st_q,    st_d;
    logic [7:0]           div_q,   div_d;
    logic                 tck_q,   tck_d;
    logic                 tms_q,   tms_d;
    logic                 tdi_q,   tdi_d;
    logic [7:0]           cnt_q,   cnt_d;
    logic [5:0]           pre_q,   pre_d;
    logic [2:0]           plen_q,  plen_d;
    logic [1:0]           op_q,    op_d;
    logic [7:0]           len_q,   len_d;
    logic [MAX_LEN-1:0]   data_q,  data_d;
    logic [MAX_LEN-1:0]   rx_q,    rx_d;
    logic                 rv_q,    rv_d;
    logic [MAX_LEN-1:0]   rd_q,    rd_d;
    logic                 tdo_meta_q;
    logic                 tdo_sync_q;
    logic                 edge_now;
    logic                 rise;
    logic                 fall;

    localparam logic [7:0] HALF_LAST = 8'(TCK_HALF_CYC - 1);
    localparam logic [8:0] MAX_LEN9  = 9'(MAX_LEN);

    // divider caps rate
    // tck flips every half period, never above the link's top rate
    assign edge_now  = (st_q != H_IDLE) && (div_q == HALF_LAST);
    assign rise      = edge_now && !tck_q;
    assign fall      = edge_now && tck_q;
    assign cmd_ready = (st_q == H_IDLE);

    // -------------------------------------------------------------
    // sequencer
    // -------------------------------------------------------------
    always_comb begin
        st_d   = st_q;
        div_d  = edge_now ? 8'h00 : ((st_q != H_IDLE) ? div_q + 8'h01 : 8'h00);
        tck_d  = edge_now ? ~tck_q : tck_q;
        tms_d  = tms_q;
        tdi_d  = tdi_q;
        cnt_d  = cnt_q;
        pre_d  = pre_q;
        plen_d = plen_q;
        op_d   = op_q;
        len_d  = len_q;
        data_d = data_q;
        rx_d   = rx_q;
        rv_d   = 1'b0;
        rd_d   = rd_q;
        unique case (st_q)
            H_IDLE: begin
                if (cmd_valid) begin
                    op_d   = cmd_op;
                    len_d  = (cmd_len == 8'h00) ? 8'h01 : cmd_len;
                    data_d = cmd_data;
                    cnt_d  = 8'h00;
                    tdi_d  = 1'b0;
                    st_d   = H_PRE;
                    unique case (cmd_op)
                        OP_IR_SCAN: begin
                            pre_d  = PRE_IR;
                            plen_d = PRE_IR_LEN;
                        end
                        OP_DR_SCAN: begin
                            pre_d  = PRE_DR;
                            plen_d = PRE_DR_LEN;
                        end
                        default: begin
                            pre_d  = PRE_RESET;
                            plen_d = PRE_RESET_LEN;
                        end
                    endcase
                    tms_d = pre_d[0];
                end
            end
            H_PRE: begin
                if (fall) begin
                    if (cnt_q == {5'h00, plen_q - 3'h1}) begin
                        cnt_d = 8'h00;
                        if (op_q == OP_IR_SCAN || op_q == OP_DR_SCAN) begin
                            st_d  = H_SHIFT;
                            tms_d = (len_q == 8'h01);
                            tdi_d = data_q[0];
                        end else begin
                            st_d = H_IDLE;
                            rv_d = 1'b1;
                            rd_d = '0;
                        end
                    end else begin
                        cnt_d = cnt_q + 8'h01;
                        pre_d = pre_q >> 1;
                        tms_d = pre_q[1];
                    end
                end
            end
            H_SHIFT: begin
                // shift in and out
                // device moved tdo on the falling edge, so it is settled here
                if (rise) begin
                    rx_d = {tdo_sync_q, rx_q[MAX_LEN-1:1]};
                end
                if (fall) begin
                    if (cnt_q == len_q - 8'h01) begin
                        st_d  = H_POST;
                        cnt_d = 8'h00;
                        tms_d = 1'b1;
                    end else begin
                        cnt_d  = cnt_q + 8'h01;
                        data_d = data_q >> 1;
                        tdi_d  = data_q[1];
                        tms_d  = (cnt_q + 8'h02 == len_q);
                    end
                end
            end
            H_POST: begin
                if (fall) begin
                    if (cnt_q == 8'h01) begin
                        st_d = H_IDLE;
                        rv_d = 1'b1;
                        rd_d = rx_q >> (MAX_LEN9 - {1'b0, len_q});
                    end else begin
                        cnt_d = 8'h01;
                        tms_d = 1'b0;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_q       <= H_IDLE;
            div_q      <= 8'h00;
            tck_q      <= 1'b0;
            tms_q      <= 1'b1;
            tdi_q      <= 1'b1;
            cnt_q      <= 8'h00;
            pre_q      <= 6'h00;
            plen_q     <= 3'h0;
            op_q       <= OP_RESET;
            len_q      <= 8'h00;
            data_q     <= '0;
            rx_q       <= '0;
            rv_q       <= 1'b0;
            rd_q       <= '0;
            tdo_meta_q <= 1'b0;
            tdo_sync_q <= 1'b0;
        end else begin
            st_q       <= st_d;
            div_q      <= div_d;
            tck_q      <= tck_d;
            tms_q      <= tms_d;
            tdi_q      <= tdi_d;
            cnt_q      <= cnt_d;
            pre_q      <= pre_d;
            plen_q     <= plen_d;
            op_q       <= op_d;
            len_q      <= len_d;
            data_q     <= data_d;
            rx_q       <= rx_d;
            rv_q       <= rv_d;
            rd_q       <= rd_d;
            tdo_meta_q <= link.tdo;
            tdo_sync_q <= tdo_meta_q;
        end
    end

    assign link.tck  = tck_q;
    assign link.tms  = tms_q;
    assign link.tdi  = tdi_q;
    assign rsp_valid = rv_q;
    assign rsp_data  = rd_q;

endmodule

// ===== shared/tap_if.sv
// serial test link between the controller and the device
`timescale 1ns/1ns
interface tap_if;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;

    modport dev (
        input  tck,
        input  tms,
        input  tdi,
        output tdo,
        output tdo_oe
    );

    modport ctl (
        output tck,
        output tms,
        output tdi,
        input  tdo,
        input  tdo_oe
    );
endinterface

// ===== shared/tap_pkg.sv
// constants and types shared by both ends of the test access port link
package tap_pkg;

    // -------------------------------------------------------------
    // register lengths and positions
    // -------------------------------------------------------------
    localparam int          IR_LEN          = 3;
    localparam int          ID_LEN          = 32;
    localparam int          BSR_LEN         = 107;
    localparam int          TRISTATE_BIT    = 47;
    localparam int          RESET_TMS_EDGES = 5;

    // -------------------------------------------------------------
    // instruction codes and capture pattern
    // -------------------------------------------------------------
    localparam logic [2:0]  IR_EXTEST       = 3'h0;
    localparam logic [2:0]  IR_IDCODE       = 3'h1;
    localparam logic [2:0]  IR_SAMPLE_Z     = 3'h2;
    localparam logic [2:0]  IR_SAMPLE_PRE   = 3'h4;
    localparam logic [2:0]  IR_BYPASS       = 3'h7;
    localparam logic [2:0]  IR_CAPTURE      = 3'h1;

    // -------------------------------------------------------------
    // values after reset
    // -------------------------------------------------------------
    localparam logic        TRISTATE_RESET  = 1'b1;
    localparam logic        BYPASS_CAPTURE  = 1'b0;

    // -------------------------------------------------------------
    // link clock derived by the controller
    // -------------------------------------------------------------
    localparam int          SYS_CLK_MHZ     = 125;
    localparam int          TCK_MAX_MHZ     = 20;
    // least half period, rounded up so the link never runs too fast
    localparam int          TCK_HALF_CYC    = (SYS_CLK_MHZ + 2 * TCK_MAX_MHZ - 1)
                                              / (2 * TCK_MAX_MHZ);

    // -------------------------------------------------------------
    // controller command opcodes
    // -------------------------------------------------------------
    localparam logic [1:0]  OP_RESET        = 2'h0;
    localparam logic [1:0]  OP_IR_SCAN      = 2'h1;
    localparam logic [1:0]  OP_DR_SCAN      = 2'h2;

    // tms preambles from run-test-idle, sent lsb first
    localparam logic [5:0]  PRE_RESET       = 6'h1f;
    localparam logic [2:0]  PRE_RESET_LEN   = 3'h6;
    localparam logic [5:0]  PRE_IR          = 6'h03;
    localparam logic [2:0]  PRE_IR_LEN      = 3'h4;
    localparam logic [5:0]  PRE_DR          = 6'h01;
    localparam logic [2:0]  PRE_DR_LEN      = 3'h3;

    typedef enum logic [3:0] {
        TEST_LOGIC_RESET, RUN_TEST_IDLE,
        SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPDATE_DR,
        SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
    } tap_state_t;

    typedef enum logic [1:0] {
        DR_BYPASS, DR_ID, DR_BOUNDARY
    } dr_sel_t;

    typedef enum logic [1:0] {
        H_IDLE, H_PRE, H_SHIFT, H_POST
    } host_state_t;

endpackage

// ===== test/boundary_scan_tap_instructions_tb_top.sv
// self-checking bench: controller and device joined by the serial link
`timescale 1ns/1ns
module boundary_scan_tap_instructions_tb_top
    import tap_pkg::*;
;
    // ---------------------------------------------------------
    // stimulus, instances and shared tasks
    // ---------------------------------------------------------
    localparam logic [31:0]  ID_VAL = 32'h1234_5679; // arbitrary value, bit 0 set
    localparam logic [106:0] PINS   = {3'h5, {13{8'hc3}}};
    localparam logic [106:0] PRE    = {3'h3, {13{8'h5a}}}; // cell 47 clear
    logic         sys_clk = 1'h0, sys_rst = 1'h1, dev_rst = 1'h1;
    logic         cmd_valid = 1'h0, func_q_oe = 1'h1;
    logic [1:0]   cmd_op = 2'h0;
    logic [7:0]   cmd_len = 8'h0;
    logic [127:0] cmd_data = 128'h0, rsp_data, r;
    logic [106:0] ring_in = PINS, ring_drive, e;
    logic         cmd_ready, rsp_valid, extest_active, q_bus_oe;
    int           n_mismatch = 0, checked = 0, cyc = 0;
    tap_if lnk ();
    tap_host #(.MAX_LEN(128)) i_tap_host (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(lnk),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_len(cmd_len),
        .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    tap_device #(.ID_CODE(ID_VAL)) i_tap_device (.link(lnk), .sys_rst(dev_rst),
        .ring_in(ring_in), .func_q_oe(func_q_oe), .ring_drive(ring_drive),
        .extest_active(extest_active), .q_bus_oe(q_bus_oe));
    tap_link_properties i_props (.sys_clk(sys_clk), .sys_rst(sys_rst), .dev_rst(dev_rst),
        .tck(lnk.tck), .tms(lnk.tms), .tdi(lnk.tdi), .tdo(lnk.tdo), .tdo_oe(lnk.tdo_oe));
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    // longest run is about 5k cycles, so this only trips on a hang
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            print_verdict;
        end
    end
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [127:0] exp, input logic [127:0] got);
        checked++;
        if (exp !== got) begin
            n_mismatch++;
            $display("Error at %0t: expected %h got %h", $time, exp, got);
        end
    endtask
    task automatic run(input logic [1:0] op, input int len, input logic [127:0] d);
        int i;
        @(negedge sys_clk);
        cmd_op = op;
        cmd_len = 8'(len);
        cmd_data = d;
        cmd_valid = 1'h1;
        @(negedge sys_clk);
        cmd_valid = 1'h0;
        chk(128'h0, 128'(cmd_ready));
        for (i = 0; i < 3000 && rsp_valid !== 1'h1; i++)
            @(negedge sys_clk);
        // a stalled command ends the run here rather than comparing stale data
        if (rsp_valid !== 1'h1) begin
            n_mismatch++;
            print_verdict;
        end else begin
            chk(128'h1, 128'(cmd_ready));
            r = rsp_data;
        end
    endtask
    task automatic t_id_bypass;
        run(OP_DR_SCAN, 32, 128'h0);
        chk(128'(ID_VAL), 128'(r[31:0]));
        run(OP_IR_SCAN, 3, 128'(IR_BYPASS));
        chk(128'(IR_CAPTURE), 128'(r[2:0]));
        run(OP_DR_SCAN, 8, 128'ha5);
        chk(128'h4a, 128'(r[7:0]));
    endtask
    task automatic t_preload;
        run(OP_IR_SCAN, 3, 128'(IR_SAMPLE_PRE));
        run(OP_DR_SCAN, 107, 128'(PRE));
        e = PINS;
        e[TRISTATE_BIT] = TRISTATE_RESET;
        chk(128'(e), 128'(r[106:0]));
        chk(128'(PRE), 128'(ring_drive));
        chk(128'(func_q_oe), 128'(q_bus_oe));
    endtask
    task automatic t_extest;
        run(OP_IR_SCAN, 3, 128'(IR_EXTEST));
        chk(128'h1, 128'(extest_active));
        chk(128'(PRE[TRISTATE_BIT]), 128'(q_bus_oe));
        chk(128'(PRE), 128'(ring_drive));
        // functional enable low, so only the latched cell can turn the bus on
        func_q_oe = 1'h0;
        run(OP_DR_SCAN, 107, 128'(~PRE));
        e[TRISTATE_BIT] = PRE[TRISTATE_BIT];
        chk(128'(e), 128'(r[106:0]));
        chk(128'h1, 128'(q_bus_oe));
        func_q_oe = 1'h1;
    endtask
    task automatic t_sample_z;
        run(OP_IR_SCAN, 3, 128'(IR_SAMPLE_Z));
        chk(128'h0, 128'(q_bus_oe));
        run(OP_DR_SCAN, 107, 128'(PRE));
        e[TRISTATE_BIT] = 1'h1;
        chk(128'(e), 128'(r[106:0]));
        chk(128'h0, 128'(q_bus_oe));
        run(OP_IR_SCAN, 3, 128'(IR_IDCODE));
        chk(128'h1, 128'(q_bus_oe));
    endtask
    task automatic t_tlr;
        run(OP_IR_SCAN, 3, 128'(IR_SAMPLE_PRE));
        run(OP_DR_SCAN, 107, 128'(PRE));
        run(OP_RESET, 1, 128'h0);
        chk(128'(TRISTATE_RESET), 128'(ring_drive[TRISTATE_BIT]));
        run(OP_DR_SCAN, 32, 128'h0);
        chk(128'(ID_VAL), 128'(r[31:0]));
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        sys_rst = 1'h0;
        // the device reset needs link clock edges, so a reset scan runs under it
        run(OP_RESET, 1, 128'h0);
        dev_rst = 1'h0;
        run(OP_RESET, 1, 128'h0);
        t_id_bypass;
        t_preload;
        t_extest;
        t_sample_z;
        t_tlr;
        print_verdict;
    end
endmodule

// ===== test/tap_link_properties.sv
// link protocol properties for the test access port
`timescale 1ns/1ns
module tap_link_properties
    import tap_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic dev_rst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    // ---------------------------------------------------------
    // shadow controller, so shift windows are known at the pins
    // ---------------------------------------------------------
    localparam logic [63:0] NX0 = 64'h1bdd_bba1_4664_4311;
    localparam logic [63:0] NX1 = 64'h2fef_cc02_8785_5920;
    logic [3:0] st_q, st_d;
    logic [2:0] sh_q, sh_d, ir_q, ir_d;
    always_comb begin
        st_d = tms ? NX1[st_q*4 +: 4] : NX0[st_q*4 +: 4];
        sh_d = (st_q == SHIFT_IR) ? {tdi, sh_q[2:1]} : sh_q;
        ir_d = (st_q == UPDATE_IR) ? sh_q : ir_q;
        if (dev_rst || st_q == TEST_LOGIC_RESET) begin
            ir_d = IR_IDCODE;
        end
        if (dev_rst) begin
            st_d = TEST_LOGIC_RESET;
        end
    end
    always_ff @(posedge tck) begin
        st_q <= st_d;
        sh_q <= sh_d;
        ir_q <= ir_d;
    end
    tck_high_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(tck) |-> tck [*4] ##1 !tck) else $error("link clock high phase wrong");
    tck_low_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $fell(tck) |-> (!tck) [*4]) else $error("link clock low phase too short");
    pins_steady_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !$stable({tms, tdi}) |-> !tck) else $error("mode or data moved while clock high");
    tdo_fall_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !$stable(tdo) |-> $fell(tck)) else $error("data out moved off the falling edge");
    oe_shift_a: assert property (@(posedge tck) disable iff (dev_rst)
        tdo_oe == (st_q == SHIFT_DR || st_q == SHIFT_IR)) else $error("output enable wrong");
    ir_capture_a: assert property (@(posedge tck) disable iff (dev_rst)
        (st_q == SHIFT_IR && $past(st_q) == CAPTURE_IR) |-> tdo ##1 (st_q != SHIFT_IR || !tdo))
        else $error("instruction capture pattern wrong");
    dr_first_a: assert property (@(posedge tck) disable iff (dev_rst)
        (st_q == SHIFT_DR && $past(st_q) == CAPTURE_DR && (ir_q == IR_IDCODE
        || ir_q == IR_BYPASS)) |-> tdo == (ir_q == IR_IDCODE)) else $error("first bit wrong");
    byp_delay_a: assert property (@(posedge tck) disable iff (dev_rst)
        (ir_q == IR_BYPASS && st_q == SHIFT_DR && $past(st_q) == SHIFT_DR)
        |-> tdo == $past(tdi)) else $error("bypass delay wrong");
endmodule
